// File: dv/pin_board.sv
// Board model at the far side: resolves each I/O pin from the array's drive.
// Assumes drive and enable come straight from the array's pin ports.
`timescale 1ns/1ps
module pin_board (
  input  wire logic       clk_i,
  input  wire logic [7:0] drive_i,
  input  wire logic [7:0] drive_en_i,
  output logic      [7:0] level_o
);
  // A released pin shows a pattern that changes every cycle.
  // A floating pin must never pass for the last driven value.
  logic [7:0] idle = 8'h5a;
  always @(posedge clk_i) begin
    idle <= ~idle;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level_o[i] = drive_en_i[i] ? drive_i[i] : idle[i];
    end
  end
endmodule

// File: dv/programmable_macrocell_array_tb.sv
// Self-checking bench of the array: registers, plane, cell modes and preload.
// Assumes the design and the board model are compiled first.
`timescale 1ns/1ps
module programmable_macrocell_array_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [11:0] adr_i = 12'h000;
  logic [31:0] dat_i = 32'h0;
  logic        we_i = 1'b0;
  logic [3:0]  sel_i = 4'h0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic [7:0]  in_i = 8'h00;
  logic        clk_pin = 1'b0;
  logic        oe_n_pin = 1'b1;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [7:0]  io_in, io_out_o, io_oe_o, pol, q, eo, ee, fbv;
  logic [31:0] masks [64];
  logic [31:0] r, lim;
  logic [2:0]  cfg;
  logic [2:0]  modes [5] = '{3'h4, 3'h7, 3'h5, 3'h3, 3'h2};
  int          n_errors = 0;
  int          n_checks = 0;
  int          seed = 72049;

  // ****************************************
  // Instances
  // ****************************************
  programmable_macrocell_array i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .in_i(in_i), .shared_clk_pin_i(clk_pin),
    .shared_oe_n_pin_i(oe_n_pin), .io_in_i(io_in), .io_out_o(io_out_o),
    .io_oe_o(io_oe_o));
  pin_board i_board (.clk_i(clk_i), .drive_i(io_out_o), .drive_en_i(io_oe_o),
    .level_o(io_in));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // ****************************************
  // Tasks and reference model
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Entered just after a rising edge; waits for ack, never for a fixed count.
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    r = dat_o;
    if (n >= 50) cmp("ack", 32'h1, 32'h0);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic term(int n);
    logic        t;
    logic [15:0] s;
    t = 1'b1;
    s = {fbv, in_i};
    for (int k = 0; k < 16; k++) begin
      if ((masks[n][2*k] && !s[k]) || (masks[n][2*k+1] && s[k])) t = 1'b0;
    end
    return t;
  endfunction

  function automatic logic sum(int c, int nt);
    logic s;
    s = 1'b0;
    for (int t = 0; t < nt; t++) s |= term(c * 8 + t);
    return s;
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    q = 8'h00;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb(1'b0, pma_pkg::ADDR_CONFIG, 32'h0);
    cmp("config", {30'h0, pma_pkg::RST_EMU, pma_pkg::RST_REG_ALLOW}, r);
    wb(1'b0, pma_pkg::ADDR_CELL, 32'h0);
    cmp("cell", {16'h0, pma_pkg::RST_POL, pma_pkg::RST_MODE}, r);
    wb(1'b0, pma_pkg::ADDR_PRELOAD, 32'h0);
    cmp("q reset", 32'h0, r);
    wb(1'b0, 12'h010, 32'h0);
    cmp("unmapped", 32'h0, r);
    for (int i = 0; i < 5; i++) begin
      cfg = modes[i];
      pol = 8'($random(seed));
      wb(1'b1, pma_pkg::ADDR_CONFIG, {30'h0, cfg[1], cfg[2]});
      wb(1'b1, pma_pkg::ADDR_CELL, {16'h0, pol, {8{cfg[0]}}});
      // Pin feedback loops through the board, so only feedback with a known source is
      // connected: the shared pins without registers, and inverted q in registered mode.
      lim = (cfg == 3'h2) ? 32'hffff_ffff : (cfg[2] ? 32'hc003_ffff : 32'h0000_ffff);
      for (int n = 0; n < 64; n++) begin
        masks[n] = $random(seed) & $random(seed) & $random(seed) & lim;
        if (n == 1) masks[n] = 32'h0;
        if (n == 9) masks[n] = 32'h3;
        wb(1'b1, pma_pkg::ADDR_PLANE + 12'(4 * n), masks[n]);
      end
      for (int j = 0; j < 4; j++) begin
        in_i <= 8'($random(seed));
        oe_n_pin <= 1'($random(seed));
        clk_pin <= 1'b0;
        repeat (3) @(posedge clk_i);
        clk_pin <= cfg[2] ? 1'($random(seed)) : 1'b1;
        repeat (3) @(posedge clk_i);
        fbv = (cfg == 3'h2) ? ~q : {clk_pin, 6'h00, oe_n_pin};
        for (int c = 0; c < 8; c++) begin
          case (cfg)
            3'h2: begin
              q[c] = sum(c, 8) ^ ~pol[c];
              eo[c] = q[c];
              ee[c] = !oe_n_pin;
            end
            3'h4: begin
              eo[c] = sum(c, 8) ^ ~pol[c];
              ee[c] = 1'b1;
            end
            3'h5: begin
              eo[c] = 1'b0;
              ee[c] = 1'b0;
            end
            default: begin
              eo[c] = sum(c, 7) ^ ~pol[c];
              ee[c] = term(c * 8 + 7);
            end
          endcase
        end
        cmp("io_oe", {24'h0, ee}, {24'h0, io_oe_o});
        cmp("io_out", {24'h0, eo}, {24'h0, io_out_o});
        wb(1'b0, pma_pkg::ADDR_PINS, 32'h0);
        cmp("pins", {16'h0, ee, eo}, r);
        if (cfg == 3'h2) begin
          wb(1'b0, pma_pkg::ADDR_PRELOAD, 32'h0);
          cmp("q", {24'h0, q}, r);
        end
      end
    end
    q = 8'($random(seed));
    oe_n_pin <= 1'b0;
    wb(1'b1, pma_pkg::ADDR_PRELOAD, {24'h0, q});
    repeat (3) @(posedge clk_i);
    wb(1'b0, pma_pkg::ADDR_PRELOAD, 32'h0);
    cmp("preload q", {24'h0, q}, r);
    cmp("preload pin", {24'h0, q}, {24'h0, io_out_o});
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb(1'b0, pma_pkg::ADDR_PRELOAD, 32'h0);
    cmp("q after reset", 32'h0, r);
    wb(1'b0, pma_pkg::ADDR_PINS, 32'h0);
    cmp("pins after reset", {16'h0, {8{!oe_n_pin}}, 8'h00}, r);
    wrap_up();
  end

  // The full run needs under 3000 cycles; the limit leaves ample slack.
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end
endmodule

// File: rtl/cell_link_if.sv
// Signals passed between the array core and one output cell.
// Assumes one instance per cell, driven from the array side.
`timescale 1ns/1ps
interface cell_link_if;
  logic [7:0] terms;
  logic       reg_allow;
  logic       emu;
  logic       mode;
  logic       pol;
  logic       edge_cell;
  logic       clk_rise;
  logic       oe_n;
  logic       preload;
  logic       preload_val;
  logic       pin_in;
  logic       adj_in;
  logic       pin_o;
  logic       pin_oe;
  logic       fb;
  logic       q;
  modport array_side (output terms, reg_allow, emu, mode, pol, edge_cell, clk_rise, oe_n,
                      output preload, preload_val, pin_in, adj_in,
                      input pin_o, pin_oe, fb, q);
  modport cell_side  (input terms, reg_allow, emu, mode, pol, edge_cell, clk_rise, oe_n,
                      input preload, preload_val, pin_in, adj_in,
                      output pin_o, pin_oe, fb, q);
endinterface

// File: rtl/output_cell.sv
// One output cell: OR sum, polarity, flip-flop, driver enable and feedback select.
// Assumes the array side supplies terms and a one-cycle shared clock rise pulse.
`timescale 1ns/1ps
module output_cell (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  cell_link_if.cell_side lnk
);
  typedef struct packed {
    logic q;
    logic pin;
    logic oe;
  } cell_state_t;
  cell_state_t cur;
  cell_state_t next_cur;
  pma_pkg::cell_cfg_t cfg;
  logic io;
  logic sum;
  logic d;
  logic fb_ctl;

  always_comb begin
    cfg = pma_pkg::cell_cfg_t'({lnk.reg_allow, lnk.emu, lnk.mode});
    io = lnk.mode & lnk.emu;
    sum = io ? |lnk.terms[pma_pkg::OE_TERM-1:0] : |lnk.terms;
    d = sum ^ ~lnk.pol;
    next_cur = cur;
    if (rst_i) begin
      next_cur = '0;
    end else begin
      if (lnk.preload) begin
        next_cur.q = lnk.preload_val;
      end else if (cfg == pma_pkg::CFG_REG && lnk.clk_rise) begin
        next_cur.q = d;
      end
      case (cfg)
        pma_pkg::CFG_REG: begin
          next_cur.pin = next_cur.q;
          next_cur.oe = ~lnk.oe_n;
        end
        pma_pkg::CFG_IO_REG, pma_pkg::CFG_IO_COMB: begin
          next_cur.pin = d;
          next_cur.oe = lnk.terms[pma_pkg::OE_TERM];
        end
        pma_pkg::CFG_COMB: begin
          next_cur.pin = d;
          next_cur.oe = 1'b1;
        end
        default: begin
          next_cur.pin = 1'b0;
          next_cur.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    cur <= next_cur;
  end

  // Edge cells neighbour the shared pins, so register allow picks their feedback.
  assign fb_ctl = lnk.edge_cell ? ~lnk.reg_allow : lnk.emu;
  assign lnk.fb = !fb_ctl ? lnk.adj_in : (lnk.mode ? lnk.pin_in : ~cur.q);
  assign lnk.pin_o = cur.pin;
  assign lnk.pin_oe = cur.oe;
  assign lnk.q = cur.q;

  AST_REG_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg == pma_pkg::CFG_REG && lnk.clk_rise && !lnk.preload) |=> (cur.q == $past(d))
    ) else $error("Register missed clock rise.");
  AST_REG_OE: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg == pma_pkg::CFG_REG) |=> (cur.oe == !$past(lnk.oe_n))
    ) else $error("Registered enable wrong.");
  AST_IO_OE: assert property (@(posedge clk_i) disable iff (rst_i)
    (io && lnk.reg_allow != lnk.emu || cfg == pma_pkg::CFG_IO_COMB)
    |=> (cur.oe == $past(lnk.terms[pma_pkg::OE_TERM]))) else $error("I/O enable wrong.");
  AST_POLARITY: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg == pma_pkg::CFG_COMB) |=> (cur.pin == ($past(|lnk.terms) ~^ $past(lnk.pol)))
    ) else $error("Polarity wrong.");
  AST_INPUT_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg == pma_pkg::CFG_INPUT) |=> !cur.oe) else $error("Input cell drives.");
  AST_PRELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    lnk.preload |=> (cur.q == $past(lnk.preload_val))) else $error("Preload lost.");
  AST_EDGE_FB: assert property (@(posedge clk_i) disable iff (rst_i)
    (lnk.edge_cell && lnk.reg_allow) |-> (lnk.fb == lnk.adj_in)) else $error("Edge fb.");
  AST_CLEAR: assert property (@(posedge clk_i)
    rst_i |=> (cur.q == 1'b0 && !cur.oe)) else $error("Reset did not clear.");
endmodule

// File: rtl/pma_pkg.sv
// Constants, types and register map of the programmable macrocell array.
// Assumes a single 40 MHz clock and a classic Wishbone slave port.
package pma_pkg;
  localparam int NCELL = 8;
  localparam int NTERM = 8;
  localparam int NCOL  = 32;
  localparam int NWORD = 64;
  localparam int AW    = 12;
  localparam int OE_TERM = 7;
  localparam logic [AW-1:0] ADDR_CONFIG  = 12'h000;
  localparam logic [AW-1:0] ADDR_CELL    = 12'h004;
  localparam logic [AW-1:0] ADDR_PRELOAD = 12'h008;
  localparam logic [AW-1:0] ADDR_PINS    = 12'h00c;
  localparam logic [AW-1:0] ADDR_PLANE   = 12'h100;
  localparam int PLANE_LSB = 2;
  localparam int PLANE_MSB = 7;
  localparam int POL_LSB   = 8;
  localparam logic       RST_REG_ALLOW = 1'h0;
  localparam logic       RST_EMU       = 1'h1;
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam logic [7:0] RST_POL       = 8'hff;
  localparam logic [NCOL-1:0] TRUE_COLS = 32'h5555_5555;
  typedef enum logic [2:0] {
    CFG_REG     = 3'h2,
    CFG_IO_REG  = 3'h3,
    CFG_COMB    = 3'h4,
    CFG_INPUT   = 3'h5,
    CFG_IO_COMB = 3'h7
  } cell_cfg_t;
endpackage

// File: rtl/programmable_macrocell_array.sv
// Top of the programmable macrocell array with its Wishbone register file.
// Assumes all pin inputs are synchronous to clk_i and a classic Wishbone master.
`timescale 1ns/1ps
module programmable_macrocell_array (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [pma_pkg::AW-1:0] adr_i,
  input  wire logic [31:0]            dat_i,
  output logic      [31:0]            dat_o,
  input  wire logic                   we_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  output logic                        ack_o,
  input  wire logic [7:0]             in_i,
  input  wire logic                   shared_clk_pin_i,
  input  wire logic                   shared_oe_n_pin_i,
  input  wire logic [7:0]             io_in_i,
  output logic      [7:0]             io_out_o,
  output logic      [7:0]             io_oe_o
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                                   reg_allow;
    logic                                   emu;
    logic [7:0]                             mode;
    logic [7:0]                             pol;
    logic [pma_pkg::NWORD-1:0][31:0]         plane;
    logic                                   ack;
    logic [31:0]                            rdata;
    logic                                   clk_prev;
    logic                                   preload;
    logic [7:0]                             preload_val;
  } top_state_t;

  top_state_t cur;
  top_state_t next_cur;
  logic       req;
  logic       clk_rise;
  logic [15:0] sig;
  logic [pma_pkg::NCOL-1:0] col;
  logic [7:0] fb_v;
  logic [7:0] q_v;
  logic [7:0] pin_v;
  logic [7:0] oe_v;
  logic       plane_hit;
  logic [pma_pkg::PLANE_MSB-pma_pkg::PLANE_LSB:0] widx;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // Array columns and shared pins
  // ****************************************
  // The shared clock pin is compared with its value at the last edge, so its rise is seen in the same cycle.
  assign clk_rise = !cur.reg_allow & shared_clk_pin_i & !cur.clk_prev;
  assign sig = {fb_v, in_i};
  for (genvar k = 0; k < 16; k++) begin : g_col
    assign col[2*k] = sig[k];
    assign col[2*k+1] = ~sig[k];
  end

  // ****************************************
  // Cells
  // ****************************************
  for (genvar c = 0; c < pma_pkg::NCELL; c++) begin : g_cell
    cell_link_if lnk ();
    term_plane u_plane (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .col_i  (col),
      .mask_i (cur.plane[c*pma_pkg::NTERM +: pma_pkg::NTERM]),
      .term_o (lnk.terms)
    );
    assign lnk.reg_allow = cur.reg_allow;
    assign lnk.emu = cur.emu;
    assign lnk.mode = cur.mode[c];
    assign lnk.pol = cur.pol[c];
    assign lnk.edge_cell = (c == 0) || (c == pma_pkg::NCELL - 1);
    assign lnk.clk_rise = clk_rise;
    assign lnk.oe_n = cur.reg_allow | shared_oe_n_pin_i;
    assign lnk.preload = cur.preload;
    assign lnk.preload_val = cur.preload_val[c];
    assign lnk.pin_in = io_in_i[c];
    if (c == 0) begin : g_first
      assign lnk.adj_in = shared_oe_n_pin_i;
    end else if (c == pma_pkg::NCELL - 1) begin : g_last
      assign lnk.adj_in = shared_clk_pin_i;
    end else begin : g_mid
      assign lnk.adj_in = io_in_i[c ^ 1];
    end
    output_cell u_cell (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .lnk   (lnk)
    );
    assign fb_v[c] = lnk.fb;
    assign q_v[c] = lnk.q;
    assign pin_v[c] = lnk.pin_o;
    assign oe_v[c] = lnk.pin_oe;
  end

  // ****************************************
  // Register file
  // ****************************************
  assign req = cyc_i & stb_i & !cur.ack;
  assign plane_hit = adr_i[pma_pkg::AW-1:pma_pkg::PLANE_MSB+1]
                     == pma_pkg::ADDR_PLANE[pma_pkg::AW-1:pma_pkg::PLANE_MSB+1];
  assign widx = adr_i[pma_pkg::PLANE_MSB:pma_pkg::PLANE_LSB];

  always_comb begin
    next_cur = cur;
    next_cur.clk_prev = shared_clk_pin_i;
    next_cur.ack = req;
    next_cur.preload = 1'b0;
    if (rst_i) begin
      next_cur = '0;
      // The edge detector follows the pin through reset, so a pin held high is no false rise.
      next_cur.clk_prev = shared_clk_pin_i;
      next_cur.reg_allow = pma_pkg::RST_REG_ALLOW;
      next_cur.emu = pma_pkg::RST_EMU;
      next_cur.mode = pma_pkg::RST_MODE;
      next_cur.pol = pma_pkg::RST_POL;
    end else if (req && we_i) begin
      if (plane_hit) begin
        next_cur.plane[widx] = merge(cur.plane[widx], dat_i, sel_i);
      end else begin
        case (adr_i)
          pma_pkg::ADDR_CONFIG: begin
            if (sel_i[0]) begin
              next_cur.reg_allow = dat_i[0];
              next_cur.emu = dat_i[1];
            end
          end
          pma_pkg::ADDR_CELL: begin
            if (sel_i[0]) begin
              next_cur.mode = dat_i[7:0];
            end
            if (sel_i[1]) begin
              next_cur.pol = dat_i[pma_pkg::POL_LSB +: 8];
            end
          end
          pma_pkg::ADDR_PRELOAD: begin
            if (sel_i[0]) begin
              next_cur.preload = 1'b1;
              next_cur.preload_val = dat_i[7:0];
            end
          end
          default: begin
            next_cur.preload = 1'b0;
          end
        endcase
      end
    end else if (req) begin
      if (plane_hit) begin
        next_cur.rdata = cur.plane[widx];
      end else begin
        case (adr_i)
          pma_pkg::ADDR_CONFIG:  next_cur.rdata = {30'h0, cur.emu, cur.reg_allow};
          pma_pkg::ADDR_CELL:    next_cur.rdata = {16'h0, cur.pol, cur.mode};
          pma_pkg::ADDR_PRELOAD: next_cur.rdata = {24'h0, q_v};
          pma_pkg::ADDR_PINS:    next_cur.rdata = {16'h0, oe_v, pin_v};
          default:               next_cur.rdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    cur <= next_cur;
  end

  assign ack_o = cur.ack;
  assign dat_o = cur.rdata;
  assign io_out_o = pin_v;
  assign io_oe_o = oe_v;

  // ****************************************
  // Checks
  // ****************************************
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    cur.ack |=> !cur.ack) else $error("Ack held too long.");
  AST_SHARED_CLK: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur.reg_allow && !cur.preload) |=> (q_v == $past(q_v)))
    else $error("Clock pin used as clock.");
  AST_PRELOAD_ALL: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == pma_pkg::ADDR_PRELOAD && sel_i[0])
    |=> ##1 (q_v == $past(dat_i[7:0], 2))) else $error("Preload not applied.");
  AST_RESET_CLEAR: assert property (@(posedge clk_i)
    rst_i |=> ##1 (q_v == 8'h00 && !cur.ack)) else $error("Reset state wrong.");
endmodule

// File: rtl/term_plane.sv
// AND plane of one cell: eight product terms over the column vector.
// Assumes masks and columns are stable between clock edges.
`timescale 1ns/1ps
module term_plane (
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_i,
  input  wire logic [pma_pkg::NCOL-1:0]              col_i,
  input  wire logic [pma_pkg::NTERM-1:0][pma_pkg::NCOL-1:0] mask_i,
  output logic      [pma_pkg::NTERM-1:0]              term_o
);
  for (genvar t = 0; t < pma_pkg::NTERM; t++) begin : g_term
    logic [pma_pkg::NCOL-1:0] pair;
    assign term_o[t] = &(col_i | ~mask_i[t]);
    assign pair = mask_i[t] & (mask_i[t] >> 1) & pma_pkg::TRUE_COLS;
    AST_EMPTY_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
      (mask_i[t] == '0) |-> term_o[t]) else $error("Empty term not high.");
    AST_BOTH_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      (|pair) |-> !term_o[t]) else $error("Contradicting term not low.");
  end
endmodule
